/* File: hdl/psgb_defines.svh */
`ifndef PSGB_DEFINES_SVH
`define PSGB_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PSGB_ADDR_CTRL 8'h00
`define PSGB_ADDR_EVT_EN 8'h04
`define PSGB_ADDR_OPER0 8'h08
`define PSGB_ADDR_REL0 8'h0c
`define PSGB_ADDR_OPER1 8'h10
`define PSGB_ADDR_REL1 8'h14
`define PSGB_ADDR_STATUS 8'h18
`define PSGB_ADDR_IRQ_STAT 8'h1c
`define PSGB_ADDR_IRQ_MASK 8'h20

// ----------------------------------------
// Field positions and counts
// ----------------------------------------
`define PSGB_CTRL_FORCE_EN 0
`define PSGB_CTRL_FORCE_LSB 1
`define PSGB_NUM_STAGES 2
`define PSGB_NUM_KINDS 3

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define PSGB_CTRL_RST 3'h0
`define PSGB_EVT_EN_RST 12'hfff
`define PSGB_OPER_DLY_RST 16'h0008
`define PSGB_REL_DLY_RST 16'h000c
`define PSGB_IRQ_MASK_RST 6'h00

`endif

/* File: hdl/psgb_pkg.sv */
package psgb_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_TRIP,
        ST_REL
    } psgb_state_t;

    typedef logic [15:0] psgb_delay_t;
    typedef logic [31:0] psgb_word_t;
    typedef logic [3:0] psgb_fault_t;
endpackage

/* File: hdl/psgb_stage.sv */
`timescale 1ns/10ps
`include "psgb_defines.svh"

module psgb_stage (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic pickup,
    input wire logic blk,
    input wire psgb_pkg::psgb_delay_t oper_dly,
    input wire psgb_pkg::psgb_delay_t rel_dly,
    input wire psgb_pkg::psgb_word_t meas,
    input wire psgb_pkg::psgb_fault_t fault,
    output logic start_ind,
    output logic trip_ind,
    output logic ind_a,
    output psgb_pkg::psgb_word_t cap_value,
    output psgb_pkg::psgb_fault_t cap_fault
);
    function automatic logic reached(input psgb_pkg::psgb_delay_t cnt,
                                     input psgb_pkg::psgb_delay_t lim);
        reached = ({1'b0, cnt} + 17'h0_0001) >= {1'b0, lim};
    endfunction

    psgb_pkg::psgb_state_t state_q, state_d;
    psgb_pkg::psgb_delay_t opcnt_q, opcnt_d;
    psgb_pkg::psgb_delay_t relcnt_q, relcnt_d;
    logic start_q, start_d;
    logic trip_q, trip_d;
    logic ind_a_q, ind_a_d;
    psgb_pkg::psgb_word_t cap_value_q, cap_value_d;
    psgb_pkg::psgb_fault_t cap_fault_q, cap_fault_d;
    logic active;

    // ----------------------------------------
    // Per processing cycle decisions
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        opcnt_d = opcnt_q;
        relcnt_d = relcnt_q;
        start_d = start_q;
        trip_d = trip_q;
        ind_a_d = ind_a_q;
        cap_value_d = cap_value_q;
        cap_fault_d = cap_fault_q;
        // Tick-sampled block level
        active = pickup & ~blk;
        if (tick) begin
            ind_a_d = pickup & blk;
            if (active) begin
                start_d = 1'b1;
                case (state_q)
                    psgb_pkg::ST_IDLE: begin
                        state_d = psgb_pkg::ST_RUN;
                        opcnt_d = '0;
                        cap_value_d = meas;
                        cap_fault_d = fault;
                    end
                    psgb_pkg::ST_REL: begin
                        state_d = psgb_pkg::ST_RUN;
                    end
                    psgb_pkg::ST_RUN: begin
                        if (reached(opcnt_q, oper_dly)) begin
                            state_d = psgb_pkg::ST_TRIP;
                            trip_d = 1'b1;
                        end else begin
                            opcnt_d = opcnt_q + 16'h0001;
                        end
                    end
                    default: begin
                        trip_d = 1'b1;
                    end
                endcase
            end else begin
                // Blocking a running start releases like a pick-up drop but also zeroes the operate count
                start_d = 1'b0;
                trip_d = 1'b0;
                case (state_q)
                    psgb_pkg::ST_RUN, psgb_pkg::ST_TRIP: begin
                        state_d = psgb_pkg::ST_REL;
                        relcnt_d = '0;
                    end
                    psgb_pkg::ST_REL: begin
                        if (reached(relcnt_q, rel_dly)) begin
                            state_d = psgb_pkg::ST_IDLE;
                            opcnt_d = '0;
                        end else begin
                            relcnt_d = relcnt_q + 16'h0001;
                        end
                    end
                    default: begin
                        state_d = psgb_pkg::ST_IDLE;
                    end
                endcase
                if (pickup & blk) begin
                    opcnt_d = '0;
                    trip_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= psgb_pkg::ST_IDLE;
            opcnt_q <= '0;
            relcnt_q <= '0;
            start_q <= 1'b0;
            trip_q <= 1'b0;
            ind_a_q <= 1'b0;
            cap_value_q <= '0;
            cap_fault_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            opcnt_q <= opcnt_d;
            relcnt_q <= relcnt_d;
            start_q <= start_d;
            trip_q <= trip_d;
            ind_a_q <= ind_a_d;
            cap_value_q <= cap_value_d;
            cap_fault_q <= cap_fault_d;
        end
    end

    assign start_ind = start_q;
    assign trip_ind = trip_q;
    assign ind_a = ind_a_q;
    assign cap_value = cap_value_q;
    assign cap_fault = cap_fault_q;
endmodule

/* File: hdl/psgb_top.sv */
`timescale 1ns/10ps
`include "psgb_defines.svh"


module psgb_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cycle_tick,
    input wire logic [1:0] pickup,
    input wire logic [1:0] block_in,
    input wire logic [31:0] meas_stage_one,
    input wire logic [31:0] meas_stage_two,
    input wire logic [3:0] fault_stage_one,
    input wire logic [3:0] fault_stage_two,
    input wire logic [31:0] time_stamp,
    output logic [1:0] start_ind,
    output logic [1:0] trip_ind,
    output logic [1:0] indication_a,
    output logic evt_valid,
    output logic [3:0] evt_code,
    output logic [31:0] evt_stamp,
    output logic [31:0] evt_value,
    output logic [3:0] evt_fault,
    output logic hmi_notify,
    output logic irq
);
    function automatic logic [3:0] first_set(input logic [11:0] v);
        first_set = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [2:0] ctrl_q, ctrl_d;
    logic [11:0] evt_en_q, evt_en_d;
    psgb_pkg::psgb_delay_t oper_q [2];
    psgb_pkg::psgb_delay_t oper_d [2];
    psgb_pkg::psgb_delay_t rel_q [2];
    psgb_pkg::psgb_delay_t rel_d [2];
    logic [5:0] irq_stat_q, irq_stat_d;
    logic [5:0] irq_mask_q, irq_mask_d;

    logic dph_wr_q, dph_wr_d;
    logic rd_wait_q, rd_wait_d;
    logic [7:0] dph_addr_q, dph_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic addr_take;
    logic [31:0] rd_mux;

    logic [1:0] blk_eff;
    logic [5:0] ind;
    logic [5:0] ind_prev_q;
    logic [11:0] new_evt;
    logic [11:0] pend_q, pend_d;
    logic [5:0] irq_set;
    logic [31:0] stamp_q, stamp_d;
    psgb_pkg::psgb_word_t meas_snap_q [2];
    psgb_pkg::psgb_word_t meas_snap_d [2];
    psgb_pkg::psgb_fault_t fault_snap_q [2];
    psgb_pkg::psgb_fault_t fault_snap_d [2];
    psgb_pkg::psgb_word_t cap_value [2];
    psgb_pkg::psgb_fault_t cap_fault [2];

    logic evt_valid_q, evt_valid_d;
    logic [3:0] evt_code_q, evt_code_d;
    logic [31:0] evt_stamp_q, evt_stamp_d;
    logic [31:0] evt_value_q, evt_value_d;
    logic [3:0] evt_fault_q, evt_fault_d;
    logic hmi_q, hmi_d;
    logic [3:0] grant;
    logic grant_stage;
    logic grant_block;

    // ----------------------------------------
    // Blocking source
    // ----------------------------------------
    always_comb begin
        if (ctrl_q[`PSGB_CTRL_FORCE_EN]) begin
            blk_eff = ctrl_q[`PSGB_CTRL_FORCE_LSB +: 2];
        end else begin
            blk_eff = block_in;
        end
    end

    psgb_stage stage_one (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .tick(cycle_tick),
        .pickup(pickup[0]),
        .blk(blk_eff[0]),
        .oper_dly(oper_q[0]),
        .rel_dly(rel_q[0]),
        .meas(meas_stage_one),
        .fault(fault_stage_one),
        .start_ind(start_ind[0]),
        .trip_ind(trip_ind[0]),
        .ind_a(indication_a[0]),
        .cap_value(cap_value[0]),
        .cap_fault(cap_fault[0])
    );

    psgb_stage stage_two (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .tick(cycle_tick),
        .pickup(pickup[1]),
        .blk(blk_eff[1]),
        .oper_dly(oper_q[1]),
        .rel_dly(rel_q[1]),
        .meas(meas_stage_two),
        .fault(fault_stage_two),
        .start_ind(start_ind[1]),
        .trip_ind(trip_ind[1]),
        .ind_a(indication_a[1]),
        .cap_value(cap_value[1]),
        .cap_fault(cap_fault[1])
    );

    assign ind = {indication_a[1], trip_ind[1], start_ind[1],
                  indication_a[0], trip_ind[0], start_ind[0]};

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    assign addr_take = hsel & hready & htrans[1];
    assign hreadyout = ~rd_wait_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (dph_addr_q)
            `PSGB_ADDR_CTRL: rd_mux = {29'h0, ctrl_q};
            `PSGB_ADDR_EVT_EN: rd_mux = {20'h0, evt_en_q};
            `PSGB_ADDR_OPER0: rd_mux = {16'h0, oper_q[0]};
            `PSGB_ADDR_REL0: rd_mux = {16'h0, rel_q[0]};
            `PSGB_ADDR_OPER1: rd_mux = {16'h0, oper_q[1]};
            `PSGB_ADDR_REL1: rd_mux = {16'h0, rel_q[1]};
            `PSGB_ADDR_STATUS: rd_mux = {26'h0, ind};
            `PSGB_ADDR_IRQ_STAT: rd_mux = {26'h0, irq_stat_q};
            `PSGB_ADDR_IRQ_MASK: rd_mux = {26'h0, irq_mask_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Reads take one wait state so a write just before is always seen
    always_comb begin
        dph_wr_d = dph_wr_q;
        dph_addr_d = dph_addr_q;
        rd_wait_d = 1'b0;
        hrdata_d = hrdata_q;
        ctrl_d = ctrl_q;
        evt_en_d = evt_en_q;
        oper_d = oper_q;
        rel_d = rel_q;
        irq_mask_d = irq_mask_q;
        if (rd_wait_q) begin
            hrdata_d = rd_mux;
        end
        if (dph_wr_q) begin
            dph_wr_d = 1'b0;
            case (dph_addr_q)
                `PSGB_ADDR_CTRL: ctrl_d = hwdata[2:0];
                `PSGB_ADDR_EVT_EN: evt_en_d = hwdata[11:0];
                `PSGB_ADDR_OPER0: oper_d[0] = hwdata[15:0];
                `PSGB_ADDR_REL0: rel_d[0] = hwdata[15:0];
                `PSGB_ADDR_OPER1: oper_d[1] = hwdata[15:0];
                `PSGB_ADDR_REL1: rel_d[1] = hwdata[15:0];
                `PSGB_ADDR_IRQ_MASK: irq_mask_d = hwdata[5:0];
                default: ;
            endcase
        end
        if (addr_take) begin
            dph_addr_d = haddr[7:0];
            dph_wr_d = hwrite;
            rd_wait_d = ~hwrite;
        end
    end

    // ----------------------------------------
    // Change detection and events
    // ----------------------------------------
    always_comb begin
        new_evt = '0;
        irq_set = '0;
        for (int s = 0; s < `PSGB_NUM_STAGES; s++) begin
            for (int k = 0; k < `PSGB_NUM_KINDS; k++) begin
                new_evt[s*6+k*2] = ind[s*3+k] & ~ind_prev_q[s*3+k];
                new_evt[s*6+k*2+1] = ~ind[s*3+k] & ind_prev_q[s*3+k];
                irq_set[s*3+k] = ind[s*3+k] & ~ind_prev_q[s*3+k];
            end
        end
        new_evt = new_evt & evt_en_q;
    end

    assign grant = first_set(pend_q);
    assign grant_stage = grant >= 4'h6;
    assign grant_block = grant_stage ? (grant >= 4'ha) : (grant >= 4'h4);

    // Drains one event per clock; a new event during drain restamps the rest
    always_comb begin
        pend_d = pend_q;
        stamp_d = stamp_q;
        meas_snap_d = meas_snap_q;
        fault_snap_d = fault_snap_q;
        evt_valid_d = 1'b0;
        evt_code_d = evt_code_q;
        evt_stamp_d = evt_stamp_q;
        evt_value_d = evt_value_q;
        evt_fault_d = evt_fault_q;
        hmi_d = indication_a[0] & ~ind_prev_q[2] | indication_a[1] & ~ind_prev_q[5];
        if (|pend_q) begin
            pend_d[grant] = 1'b0;
            evt_valid_d = 1'b1;
            evt_code_d = grant;
            evt_stamp_d = stamp_q;
            if (grant_block) begin
                evt_value_d = cap_value[grant_stage];
                evt_fault_d = cap_fault[grant_stage];
            end else begin
                evt_value_d = meas_snap_q[grant_stage];
                evt_fault_d = fault_snap_q[grant_stage];
            end
        end
        if (|new_evt) begin
            pend_d = pend_d | new_evt;
            stamp_d = time_stamp;
            meas_snap_d[0] = meas_stage_one;
            meas_snap_d[1] = meas_stage_two;
            fault_snap_d[0] = fault_stage_one;
            fault_snap_d[1] = fault_stage_two;
        end
        // New events win over the write-one clear
        irq_stat_d = irq_stat_q;
        if (dph_wr_q && dph_addr_q == `PSGB_ADDR_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~hwdata[5:0];
        end
        irq_stat_d = irq_stat_d | irq_set;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dph_wr_q <= 1'b0;
            dph_addr_q <= 8'h00;
            rd_wait_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
            ctrl_q <= `PSGB_CTRL_RST;
            evt_en_q <= `PSGB_EVT_EN_RST;
            oper_q[0] <= `PSGB_OPER_DLY_RST;
            oper_q[1] <= `PSGB_OPER_DLY_RST;
            rel_q[0] <= `PSGB_REL_DLY_RST;
            rel_q[1] <= `PSGB_REL_DLY_RST;
            irq_mask_q <= `PSGB_IRQ_MASK_RST;
            irq_stat_q <= 6'h00;
            ind_prev_q <= 6'h00;
            pend_q <= 12'h000;
            stamp_q <= 32'h0000_0000;
            meas_snap_q[0] <= 32'h0000_0000;
            meas_snap_q[1] <= 32'h0000_0000;
            fault_snap_q[0] <= 4'h0;
            fault_snap_q[1] <= 4'h0;
            evt_valid_q <= 1'b0;
            evt_code_q <= 4'h0;
            evt_stamp_q <= 32'h0000_0000;
            evt_value_q <= 32'h0000_0000;
            evt_fault_q <= 4'h0;
            hmi_q <= 1'b0;
        end else if (clk_en) begin
            dph_wr_q <= dph_wr_d;
            dph_addr_q <= dph_addr_d;
            rd_wait_q <= rd_wait_d;
            hrdata_q <= hrdata_d;
            ctrl_q <= ctrl_d;
            evt_en_q <= evt_en_d;
            oper_q <= oper_d;
            rel_q <= rel_d;
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
            ind_prev_q <= ind;
            pend_q <= pend_d;
            stamp_q <= stamp_d;
            meas_snap_q <= meas_snap_d;
            fault_snap_q <= fault_snap_d;
            evt_valid_q <= evt_valid_d;
            evt_code_q <= evt_code_d;
            evt_stamp_q <= evt_stamp_d;
            evt_value_q <= evt_value_d;
            evt_fault_q <= evt_fault_d;
            hmi_q <= hmi_d;
        end
    end

    assign evt_valid = evt_valid_q;
    assign evt_code = evt_code_q;
    assign evt_stamp = evt_stamp_q;
    assign evt_value = evt_value_q;
    assign evt_fault = evt_fault_q;
    assign hmi_notify = hmi_q;
    assign irq = |(irq_stat_q & irq_mask_q);
endmodule

/* File: tb/psgb_asserts.sv */
`timescale 1ns/10ps

module psgb_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic cycle_tick,
    input wire logic [1:0] pickup,
    input wire logic [1:0] start_ind,
    input wire logic [1:0] trip_ind,
    input wire logic [1:0] indication_a,
    input wire logic evt_valid,
    input wire logic [3:0] evt_code,
    input wire logic [31:0] evt_stamp,
    input wire logic hmi_notify
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    wire logic tk = cycle_tick && clk_en;

    // ----------------------------------------
    // Stage decisions
    // ----------------------------------------
    chk_blk_excl: assert property ((indication_a & (start_ind | trip_ind)) == 2'b00)
        else $error("start or trip while indication_a");
    chk_tick_only: assert property ($changed({start_ind, trip_ind, indication_a}) |-> $past(tk))
        else $error("change off a tick");
    chk_start_cause: assert property ($rose(start_ind[0]) |-> $past(tk && pickup[0]) && !indication_a[0])
        else $error("start without pickup");
    chk_blk_cause: assert property ($rose(indication_a[1]) |-> $past(tk && pickup[1]))
        else $error("indication_a without pickup");
    chk_hmi_blk: assert property (($rose(indication_a[0]) || $rose(indication_a[1])) |=> hmi_notify)
        else $error("no display notice");
    chk_trip_start: assert property ($rose(trip_ind[0]) |-> $past(start_ind[0]) && start_ind[0])
        else $error("trip without running start");
    chk_start_drop: assert property ($fell(start_ind[0]) |-> indication_a[0] || $past(!pickup[0]))
        else $error("start dropped without cause");

    // ----------------------------------------
    // Events
    // ----------------------------------------
    chk_evt_hold: assert property (!evt_valid |-> $stable(evt_code) && $stable(evt_stamp))
        else $error("event data moved");
    chk_evt_stage: assert property ($rose(start_ind[1]) |-> ##[1:14] (evt_valid && evt_code == 4'h6))
        else $error("no start event");

    cov_trip: cover property ($rose(trip_ind[0]));
    cov_blk_run: cover property ($rose(indication_a[0]) && $past(start_ind[0]));
    cov_blk_evt: cover property (evt_valid && evt_code == 4'h4);
endmodule

bind psgb_top psgb_asserts u_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .cycle_tick(cycle_tick), .pickup(pickup), .start_ind(start_ind), .trip_ind(trip_ind),
    .indication_a(indication_a), .evt_valid(evt_valid), .evt_code(evt_code),
    .evt_stamp(evt_stamp), .hmi_notify(hmi_notify));

/* File: tb/psgb_partner.sv */
`timescale 1ns/10ps

module psgb_partner (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] blk_req,
    output logic [1:0] block_in,
    input wire logic evt_valid,
    input wire logic [3:0] evt_code,
    input wire logic [31:0] evt_stamp,
    input wire logic [31:0] evt_value,
    input wire logic [3:0] evt_fault,
    input wire logic hmi_notify
);
    logic [3:0] code_q[$];
    logic [31:0] stamp_q[$];
    logic [31:0] value_q[$];
    logic [3:0] fault_q[$];
    int hmi_cnt = 0;

    // Registered matrix level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            block_in <= 2'b00;
        end else begin
            block_in <= blk_req;
        end
    end

    // No back-pressure: every pulse taken at once
    always @(posedge clk) begin
        if (evt_valid) begin
            code_q.push_back(evt_code);
            stamp_q.push_back(evt_stamp);
            value_q.push_back(evt_value);
            fault_q.push_back(evt_fault);
        end
        if (hmi_notify) begin
            hmi_cnt++;
        end
    end

    task automatic clear();
        code_q.delete();
        stamp_q.delete();
        value_q.delete();
        fault_q.delete();
        hmi_cnt = 0;
    endtask
endmodule

/* File: tb/psgb_tb_top.sv */
`timescale 1ns/10ps
`include "psgb_defines.svh"

module psgb_tb_top;
    logic clk;
    logic reset_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic cycle_tick;
    logic [1:0] tick_cnt;
    logic [1:0] pickup;
    logic [1:0] blk_req;
    logic [1:0] block_in;
    logic [31:0] meas_one;
    logic [3:0] fault_one;
    logic [31:0] time_stamp;
    logic [1:0] start_ind;
    logic [1:0] trip_ind;
    logic [1:0] indication_a;
    logic evt_valid;
    logic [3:0] evt_code;
    logic [31:0] evt_stamp;
    logic [31:0] evt_value;
    logic [3:0] evt_fault;
    logic hmi_notify;
    logic irq;
    logic [31:0] dmy;
    int n;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    wire logic [5:0] ind_v = {indication_a, trip_ind, start_ind};
    logic [7:0] ra [9] = '{`PSGB_ADDR_CTRL, `PSGB_ADDR_EVT_EN, `PSGB_ADDR_OPER0,
        `PSGB_ADDR_REL0, `PSGB_ADDR_OPER1, `PSGB_ADDR_REL1, `PSGB_ADDR_STATUS,
        `PSGB_ADDR_IRQ_STAT, `PSGB_ADDR_IRQ_MASK};
    logic [31:0] rv [9] = '{32'h0000_0000, 32'h0000_0fff, 32'h0000_0008, 32'h0000_000c,
        32'h0000_0008, 32'h0000_000c, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    psgb_top uut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .cycle_tick(cycle_tick),
        .pickup(pickup), .block_in(block_in), .meas_stage_one(meas_one),
        .meas_stage_two(32'h2222_0001), .fault_stage_one(fault_one), .fault_stage_two(4'h9),
        .time_stamp(time_stamp), .start_ind(start_ind), .trip_ind(trip_ind),
        .indication_a(indication_a), .evt_valid(evt_valid), .evt_code(evt_code),
        .evt_stamp(evt_stamp), .evt_value(evt_value), .evt_fault(evt_fault),
        .hmi_notify(hmi_notify), .irq(irq));

    psgb_partner u_partner (.clk(clk), .reset_n(reset_n), .blk_req(blk_req),
        .block_in(block_in), .evt_valid(evt_valid), .evt_code(evt_code),
        .evt_stamp(evt_stamp), .evt_value(evt_value), .evt_fault(evt_fault),
        .hmi_notify(hmi_notify));

    // ----------------------------------------
    // Clock, tick every 4 cycles, timeout
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        cycle_tick <= (tick_cnt == 2'h2);
        time_stamp <= time_stamp + 32'h0000_0001;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_rdy(output logic [31:0] d);
        logic r;
        r = 1'b0;
        while (!r) begin
            @(negedge clk);
            r = hreadyout;
            d = hrdata;
            @(posedge clk);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic [31:0] x;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_rdy(x);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(rd);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, dmy);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000, dmy);
        chk(nm, e, dmy);
    endtask

    task automatic wait_for(input int i, input logic v, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (ind_v[i] !== v && cnt < 200);
        @(posedge clk);
    endtask

    task automatic chk_q(input logic [11:0] codes);
        chk("event count", 3, u_partner.code_q.size());
        for (int k = 0; k < 3; k++) begin
            chk("event code", {28'h000_0000, codes[k*4 +: 4]}, u_partner.code_q[k]);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        pickup = 2'b00;
        blk_req = 2'b00;
        meas_one = 32'h1111_0001;
        fault_one = 4'h5;
        time_stamp = 32'h0000_0000;
        tick_cnt = 2'h0;
        cycle_tick = 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rdc("reset value", ra[i], rv[i]);
        end
        wr(`PSGB_ADDR_STATUS, 32'hffff_ffff);
        rdc("status read only", `PSGB_ADDR_STATUS, 32'h0000_0000);
        rdc("unmapped", 8'h24, 32'h0000_0000);
        // Two delays; stage one start-on disabled
        wr(`PSGB_ADDR_EVT_EN, 32'h0000_0ffe);
        wr(`PSGB_ADDR_OPER0, 32'h0000_0003);
        wr(`PSGB_ADDR_OPER1, 32'h0000_0005);
        pickup <= 2'b11;
        wait_for(0, 1'b1, n);
        chk("start two", 1, start_ind[1]);
        wait_for(2, 1'b1, n);
        chk("operate delay one", 12, n);
        wait_for(3, 1'b1, n);
        chk("operate delay two", 8, n);
        repeat (8) @(posedge clk);
        chk_q({4'h8, 4'h2, 4'h6});
        chk("stamp gap one", 12, u_partner.stamp_q[1] - u_partner.stamp_q[0]);
        chk("stamp gap two", 8, u_partner.stamp_q[2] - u_partner.stamp_q[1]);
        chk("trip value", 32'h1111_0001, u_partner.value_q[1]);
        rdc("status", `PSGB_ADDR_STATUS, 32'h0000_001b);
        rdc("irq status", `PSGB_ADDR_IRQ_STAT, 32'h0000_001b);
        chk("irq masked", 0, irq);
        wr(`PSGB_ADDR_IRQ_MASK, 32'h0000_0002);
        @(negedge clk);
        chk("irq raised", 1, irq);
        wr(`PSGB_ADDR_IRQ_STAT, 32'h0000_0002);
        @(negedge clk);
        chk("irq cleared", 0, irq);
        rdc("irq stat cleared", `PSGB_ADDR_IRQ_STAT, 32'h0000_0019);
        // Blocking a tripped stage
        u_partner.clear();
        meas_one <= 32'h1111_0003;
        fault_one <= 4'h6;
        blk_req <= 2'b01;
        wait_for(4, 1'b1, n);
        chk("start dropped", 0, start_ind[0]);
        chk("trip dropped", 0, trip_ind[0]);
        chk("stage two unaffected", 1, trip_ind[1]);
        repeat (8) @(posedge clk);
        chk_q({4'h4, 4'h3, 4'h1});
        chk("block value", 32'h1111_0001, u_partner.value_q[2]);
        chk("block fault", 5, u_partner.fault_q[2]);
        chk("start off value", 32'h1111_0003, u_partner.value_q[0]);
        chk("display notice", 1, u_partner.hmi_cnt);
        pickup <= 2'b00;
        blk_req <= 2'b00;
        wait_for(3, 1'b0, n);
        wait_for(4, 1'b0, n);
        // Pick-up while indication_a
        blk_req <= 2'b10;
        repeat (4) @(posedge clk);
        pickup <= 2'b10;
        wait_for(5, 1'b1, n);
        chk("indication_a on", 1, indication_a[1]);
        repeat (40) @(posedge clk);
        chk("no start or trip", 0, {start_ind[1], trip_ind[1]});
        pickup <= 2'b00;
        wait_for(5, 1'b0, n);
        chk("indication_a off", 0, indication_a[1]);
        blk_req <= 2'b00;
        // Forced blocking
        wr(`PSGB_ADDR_CTRL, 32'h0000_0003);
        rdc("control", `PSGB_ADDR_CTRL, 32'h0000_0003);
        pickup <= 2'b01;
        wait_for(4, 1'b1, n);
        chk("forced block", 0, start_ind[0]);
        wr(`PSGB_ADDR_CTRL, 32'h0000_0000);
        wait_for(0, 1'b1, n);
        chk("start after unforce", 0, indication_a[0]);
        pickup <= 2'b00;
        repeat (8) @(posedge clk);
        end_of_test();
    end
endmodule
